// file: core/rbt_capture_reg.sv
// One storage register loaded on rising edges of a capture clock pin.
`timescale 1ns/100ps
module rbt_capture_reg
    import rbt_pkg::*;
#(
    parameter int WIDTH = RBT_DATA_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic cap_clk_pin,
    input wire logic [WIDTH-1:0] data_sync,
    output logic [WIDTH-1:0] store_q,
    output logic capture_q
);

    logic cap_meta_q;
    logic cap_sync_q;
    logic cap_prev_q;

    initial begin
        if (WIDTH < 1) begin
            $error("rbt_capture_reg: WIDTH must be at least 1");
        end
    end

    // Two flops before the pin is looked at; the pin is asynchronous
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cap_meta_q <= 1'b0;
            cap_sync_q <= 1'b0;
        end else begin
            cap_meta_q <= cap_clk_pin;
            cap_sync_q <= cap_meta_q;
        end
    end

    // Previous level for the rising-edge test
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cap_prev_q <= 1'b0;
        end else begin
            cap_prev_q <= cap_sync_q;
        end
    end

    // Load on each rising edge only, no output gating at all
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            store_q <= '0;
        end else if (cap_sync_q && !cap_prev_q) begin
            store_q <= data_sync;
        end // Static clock keeps the value
    end

    // One-cycle pulse per capture, for counters
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            capture_q <= 1'b0;
        end else begin
            capture_q <= cap_sync_q && !cap_prev_q;
        end
    end

endmodule : rbt_capture_reg

// file: core/rbt_pkg.sv
// Constants and types shared by the registered inverting bus transceiver.
// What this block does
// - Capture clocks load A and B registers
// - Capture ignores enable and direction controls
// - Enable high: both buses inputs, high impedance
// - Enable low: direction picks driven bus, unless the control isolate bit is set
// - Never drive both buses together
// - Source select: live bus or stored register
// - A bus gets live B data
// - A bus gets inverted B register
// - B bus gets inverted live A
// - B bus gets inverted A register
// - Input bus still captured while driving
package rbt_pkg;

    // Bus geometry
    localparam int RBT_DATA_W = 8;
    localparam int RBT_SYNC_STAGES = 2;

    // AXI4-Lite register map, byte addresses
    localparam int RBT_ADDR_W = 5;
    localparam logic [4:0] RBT_CTRL_OFS = 5'h00;
    localparam logic [4:0] RBT_A_STORE_OFS = 5'h04;
    localparam logic [4:0] RBT_B_STORE_OFS = 5'h08;
    localparam logic [4:0] RBT_STATUS_OFS = 5'h0c;
    localparam logic [4:0] RBT_COUNT_OFS = 5'h10;

    // Control register fields
    localparam int RBT_CTRL_ISOLATE_BIT = 0;
    localparam int RBT_CTRL_CLR_CNT_BIT = 1;
    localparam logic [31:0] RBT_CTRL_RESET = 32'h0000_0000;

    // Status register fields
    localparam int RBT_ST_OE_N_BIT = 0;
    localparam int RBT_ST_DIR_BIT = 1;
    localparam int RBT_ST_A_SRC_BIT = 2;
    localparam int RBT_ST_B_SRC_BIT = 3;
    localparam int RBT_ST_A_DRV_BIT = 4;
    localparam int RBT_ST_B_DRV_BIT = 5;

    // Capture counters, A in low half, B in high half
    localparam int RBT_CNT_W = 16;
    localparam int RBT_CNT_B_LSB = 16;

    // AXI responses
    localparam logic [1:0] RBT_RESP_OKAY = 2'h0;
    localparam logic [1:0] RBT_RESP_SLVERR = 2'h2;

    // Which bus the transceiver currently drives
    typedef enum logic [1:0] {
        RBT_DRV_NONE = 2'b00,
        RBT_DRV_A = 2'b01,
        RBT_DRV_B = 2'b10
    } rbt_drive_type;

endpackage : rbt_pkg

// file: core/rbt_transceiver.sv
// Registered inverting bus transceiver with an AXI4-Lite register port.
`timescale 1ns/100ps
module rbt_transceiver
    import rbt_pkg::*;
#(
    parameter int DATA_W = RBT_DATA_W,
    parameter int CNT_W = RBT_CNT_W
) (
    input wire logic clk,
    input wire logic rst,
    // Bus A pins
    input wire logic [DATA_W-1:0] a_bus_in,
    output logic [DATA_W-1:0] a_bus_out,
    output logic a_bus_oe_n,
    // Bus B pins
    input wire logic [DATA_W-1:0] b_bus_in,
    output logic [DATA_W-1:0] b_bus_out,
    output logic b_bus_oe_n,
    // Control pins
    input wire logic output_enable_n,
    input wire logic direction_select,
    input wire logic a_bus_source_select,
    input wire logic b_bus_source_select,
    input wire logic a_to_b_capture_clock,
    input wire logic b_to_a_capture_clock,
    // AXI4-Lite write address
    input wire logic [RBT_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [RBT_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    localparam int CTL_W = 4;

    logic [DATA_W-1:0] a_meta_q;
    logic [DATA_W-1:0] a_live_q;
    logic [DATA_W-1:0] b_meta_q;
    logic [DATA_W-1:0] b_live_q;
    logic [CTL_W-1:0] ctl_meta_q;
    logic [CTL_W-1:0] ctl_sync_q;
    logic oe_n_s;
    logic dir_s;
    logic a_src_s;
    logic b_src_s;

    logic [DATA_W-1:0] a_store;
    logic [DATA_W-1:0] b_store;
    logic a_cap_pulse;
    logic b_cap_pulse;

    rbt_drive_type drive_d;
    rbt_drive_type drive_q;
    logic [DATA_W-1:0] a_out_d;
    logic [DATA_W-1:0] b_out_d;

    logic isolate_q;
    logic [CNT_W-1:0] a_cnt_q;
    logic [CNT_W-1:0] b_cnt_q;
    logic clr_cnt;

    logic aw_held_q;
    logic w_held_q;
    logic [RBT_ADDR_W-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic do_write;
    logic do_read;

    initial begin
        if (DATA_W < 1 || DATA_W > 16) begin
            $error("rbt_transceiver: DATA_W must be 1 to 16");
        end
        if (CNT_W < 1 || CNT_W > RBT_CNT_B_LSB) begin
            $error("rbt_transceiver: CNT_W must be 1 to 16");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Widen a bus value into a 32-bit register word
    function automatic logic [31:0] rbt_word(input logic [DATA_W-1:0] v);
        logic [31:0] w;
        w = '0;
        w[DATA_W-1:0] = v;
        return w;
    endfunction : rbt_word

    // Next value of a saturating capture counter
    function automatic logic [CNT_W-1:0] rbt_count(
        input logic [CNT_W-1:0] c,
        input logic inc
    );
        logic [CNT_W-1:0] n;
        n = c;
        if (inc && c != {CNT_W{1'b1}}) begin
            n = c + 1'b1;
        end
        return n;
    endfunction : rbt_count

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    // Bus data from outside the clock domain, two flops each
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            a_meta_q <= '0;
            a_live_q <= '0;
            b_meta_q <= '0;
            b_live_q <= '0;
        end else begin
            a_meta_q <= a_bus_in;
            a_live_q <= a_meta_q;
            b_meta_q <= b_bus_in;
            b_live_q <= b_meta_q;
        end
    end

    // Control pins; reset value reads as isolated so nothing drives early
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctl_meta_q <= 4'h1;
            ctl_sync_q <= 4'h1;
        end else begin
            ctl_meta_q <= {b_bus_source_select, a_bus_source_select,
                           direction_select, output_enable_n};
            ctl_sync_q <= ctl_meta_q;
        end
    end

    assign oe_n_s = ctl_sync_q[0];
    assign dir_s = ctl_sync_q[1];
    assign a_src_s = ctl_sync_q[2];
    assign b_src_s = ctl_sync_q[3];

    ////////////////////////////////////////////////////////////////////////////
    // Storage registers

    // A-side register, fed from bus A whatever the bus controls say
    rbt_capture_reg #(
        .WIDTH(DATA_W)
    ) u_a_reg (
        .clk(clk),
        .rst(rst),
        .cap_clk_pin(a_to_b_capture_clock),
        .data_sync(a_live_q),
        .store_q(a_store),
        .capture_q(a_cap_pulse)
    );

    // B-side register, fed from bus B; also loads while isolated
    rbt_capture_reg #(
        .WIDTH(DATA_W)
    ) u_b_reg (
        .clk(clk),
        .rst(rst),
        .cap_clk_pin(b_to_a_capture_clock),
        .data_sync(b_live_q),
        .store_q(b_store),
        .capture_q(b_cap_pulse)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Drive selection

    // One mode at a time, so both enables can never be low together
    always_comb begin
        if (oe_n_s || isolate_q) begin
            drive_d = RBT_DRV_NONE;
        end else if (dir_s) begin
            drive_d = RBT_DRV_B;
        end else begin
            drive_d = RBT_DRV_A;
        end
    end

    // Data paths: live or stored, inverting except live B to A
    always_comb begin
        a_out_d = a_src_s ? ~b_store : b_live_q;
        b_out_d = b_src_s ? ~a_store : ~a_live_q;
    end

    // Pin drivers are flops; one cycle added after the synchronisers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            drive_q <= RBT_DRV_NONE;
            a_bus_oe_n <= 1'b1;
            b_bus_oe_n <= 1'b1;
        end else begin
            drive_q <= drive_d;
            unique case (drive_d)
                RBT_DRV_A: begin
                    a_bus_oe_n <= 1'b0;
                    b_bus_oe_n <= 1'b1;
                end
                RBT_DRV_B: begin
                    a_bus_oe_n <= 1'b1;
                    b_bus_oe_n <= 1'b0;
                end
                default: begin
                    a_bus_oe_n <= 1'b1;
                    b_bus_oe_n <= 1'b1;
                end
            endcase
        end
    end

    // Output data follow the selected source every cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            a_bus_out <= '0;
            b_bus_out <= '0;
        end else begin
            a_bus_out <= a_out_d;
            b_bus_out <= b_out_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Capture counters

    // Saturating counts so software can see edges were taken
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            a_cnt_q <= '0;
            b_cnt_q <= '0;
        end else if (clr_cnt) begin
            // A capture in the clearing cycle still counts
            a_cnt_q <= {{(CNT_W-1){1'b0}}, a_cap_pulse};
            b_cnt_q <= {{(CNT_W-1){1'b0}}, b_cap_pulse};
        end else begin
            a_cnt_q <= rbt_count(a_cnt_q, a_cap_pulse);
            b_cnt_q <= rbt_count(b_cnt_q, b_cap_pulse);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write side

    // Address and data may arrive in either order
    assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
    assign clr_cnt = do_write && aw_addr_q == RBT_CTRL_OFS
                     && w_strb_q[0] && w_data_q[RBT_CTRL_CLR_CNT_BIT];

    // Write address channel; ready only while no address is held
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= '0;
            s_axi_awready <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (do_write) begin
                aw_held_q <= 1'b0;
            end else begin
                s_axi_awready <= !aw_held_q;
            end
        end
    end

    // Write data channel, mirror of the address channel
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            w_held_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
            s_axi_wready <= 1'b0;
        end else begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (do_write) begin
                w_held_q <= 1'b0;
            end else begin
                s_axi_wready <= !w_held_q;
            end
        end
    end

    // Control register: only the isolate bit is stored
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            isolate_q <= RBT_CTRL_RESET[RBT_CTRL_ISOLATE_BIT];
        end else if (do_write && aw_addr_q == RBT_CTRL_OFS && w_strb_q[0]) begin
            isolate_q <= w_data_q[RBT_CTRL_ISOLATE_BIT];
        end
    end

    // Write response; writes to anything but control are refused
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RBT_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (aw_addr_q == RBT_CTRL_OFS) ? RBT_RESP_OKAY
                                                       : RBT_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read side

    assign do_read = s_axi_arvalid && s_axi_arready;

    // One read at a time; address ready drops while data wait
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
        end else if (do_read) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= !s_axi_rvalid;
        end
    end

    // Read data sampled at the address handshake
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RBT_RESP_OKAY;
        end else if (do_read) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RBT_RESP_OKAY;
            unique case (s_axi_araddr)
                RBT_CTRL_OFS: begin
                    s_axi_rdata <= '0;
                    s_axi_rdata[RBT_CTRL_ISOLATE_BIT] <= isolate_q;
                end
                RBT_A_STORE_OFS: begin
                    s_axi_rdata <= rbt_word(a_store);
                end
                RBT_B_STORE_OFS: begin
                    s_axi_rdata <= rbt_word(b_store);
                end
                RBT_STATUS_OFS: begin
                    s_axi_rdata <= '0;
                    s_axi_rdata[RBT_ST_OE_N_BIT] <= oe_n_s;
                    s_axi_rdata[RBT_ST_DIR_BIT] <= dir_s;
                    s_axi_rdata[RBT_ST_A_SRC_BIT] <= a_src_s;
                    s_axi_rdata[RBT_ST_B_SRC_BIT] <= b_src_s;
                    s_axi_rdata[RBT_ST_A_DRV_BIT] <= (drive_q == RBT_DRV_A);
                    s_axi_rdata[RBT_ST_B_DRV_BIT] <= (drive_q == RBT_DRV_B);
                end
                RBT_COUNT_OFS: begin
                    s_axi_rdata <= '0;
                    s_axi_rdata[CNT_W-1:0] <= a_cnt_q;
                    s_axi_rdata[RBT_CNT_B_LSB +: CNT_W] <= b_cnt_q;
                end
                default: begin
                    // Unmapped word: zero data and a slave error
                    s_axi_rdata <= '0;
                    s_axi_rresp <= RBT_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule : rbt_transceiver

// file: test/rbt_bus_partner.sv
// Far-side system logic driving each bus whenever the device lets go.
`timescale 1ns/100ps
module rbt_bus_partner
    import rbt_pkg::*;
(
    input wire logic [RBT_DATA_W-1:0] a_val,
    input wire logic [RBT_DATA_W-1:0] b_val,
    input wire logic [RBT_DATA_W-1:0] a_bus_out,
    input wire logic a_bus_oe_n,
    input wire logic [RBT_DATA_W-1:0] b_bus_out,
    input wire logic b_bus_oe_n,
    output logic [RBT_DATA_W-1:0] a_bus_in,
    output logic [RBT_DATA_W-1:0] b_bus_in
);
    // Wire level: device drive wins, so a driven bus reads back its own value
    assign a_bus_in = a_bus_oe_n ? a_val : a_bus_out;
    assign b_bus_in = b_bus_oe_n ? b_val : b_bus_out;
endmodule : rbt_bus_partner

// file: test/rbt_transceiver_assertions.sv
// Checker for the transceiver pins and register bus answers.
`timescale 1ns/100ps
module rbt_transceiver_assertions
    import rbt_pkg::*;
#(
    parameter int DATA_W = RBT_DATA_W,
    parameter int CNT_W = RBT_CNT_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [DATA_W-1:0] a_bus_in,
    input wire logic [DATA_W-1:0] a_bus_out,
    input wire logic a_bus_oe_n,
    input wire logic [DATA_W-1:0] b_bus_in,
    input wire logic [DATA_W-1:0] b_bus_out,
    input wire logic b_bus_oe_n,
    input wire logic output_enable_n,
    input wire logic direction_select,
    input wire logic a_bus_source_select,
    input wire logic b_bus_source_select,
    input wire logic a_to_b_capture_clock,
    input wire logic b_to_a_capture_clock,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic [DATA_W-1:0] shadow_a_q;
    logic [DATA_W-1:0] shadow_b_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////
    // Shadow stores on clk like the design, so pin edges line up
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shadow_a_q <= '0;
            shadow_b_q <= '0;
        end else begin
            if ($rose(a_to_b_capture_clock)) shadow_a_q <= a_bus_in;
            if ($rose(b_to_a_capture_clock)) shadow_b_q <= b_bus_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output paths; windows allow for the three-edge pin latency
    property p_one_side;
        !(!a_bus_oe_n && !b_bus_oe_n);
    endproperty
    a_one_side: assert property (p_one_side) else $error("both buses driven");

    property p_isolate;
        output_enable_n [*4] |-> a_bus_oe_n && b_bus_oe_n;
    endproperty
    a_isolate: assert property (p_isolate) else $error("bus driven while disabled");

    property p_drive_a;
        (!output_enable_n && !direction_select) [*4] |-> !a_bus_oe_n && b_bus_oe_n;
    endproperty
    a_drive_a: assert property (p_drive_a) else $error("wrong bus driven");

    property p_live_a;
        (!output_enable_n && !direction_select && !a_bus_source_select && $stable(b_bus_in)) [*4]
            |-> a_bus_out == $past(b_bus_in, 3);
    endproperty
    a_live_a: assert property (p_live_a) else $error("live A path wrong");

    property p_live_b;
        (!output_enable_n && direction_select && !b_bus_source_select && $stable(a_bus_in)) [*4]
            |-> !b_bus_oe_n && b_bus_out == ~$past(a_bus_in, 3);
    endproperty
    a_live_b: assert property (p_live_b) else $error("live B path wrong");

    property p_store_a;
        (!output_enable_n && !direction_select && a_bus_source_select
            && !$rose(b_to_a_capture_clock)) [*5] |-> a_bus_out == ~shadow_b_q;
    endproperty
    a_store_a: assert property (p_store_a) else $error("stored A path wrong");

    property p_store_b;
        (!output_enable_n && direction_select && b_bus_source_select
            && !$rose(a_to_b_capture_clock)) [*5] |-> b_bus_out == ~shadow_a_q;
    endproperty
    a_store_b: assert property (p_store_b) else $error("stored B path wrong");

    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write answer dropped");

    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read answer dropped");

    c_drive_a: cover property (!a_bus_oe_n);
    c_drive_b: cover property (!b_bus_oe_n);
    c_slverr: cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == RBT_RESP_SLVERR);

endmodule : rbt_transceiver_assertions

bind rbt_transceiver rbt_transceiver_assertions #(.DATA_W(DATA_W), .CNT_W(CNT_W)) u_rbt_chk (.*);

// file: test/tb_top.sv
// Self-checking bench for the registered inverting bus transceiver.
`timescale 1ns/100ps
module tb_top;
    import rbt_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic output_enable_n = 1'b1;
    logic direction_select = 1'b0;
    logic a_bus_source_select = 1'b0;
    logic b_bus_source_select = 1'b0;
    logic a_to_b_capture_clock = 1'b0;
    logic b_to_a_capture_clock = 1'b0;
    logic [7:0] a_val = 8'h00;
    logic [7:0] b_val = 8'h00;
    logic [7:0] a_bus_in, a_bus_out, b_bus_in, b_bus_out, a_reg, b_reg;
    logic a_bus_oe_n, b_bus_oe_n, s_axi_awready, s_axi_wready, s_axi_arready;
    logic [4:0] s_axi_awaddr = 5'h00;
    logic [4:0] s_axi_araddr = 5'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [31:0] s_axi_rdata, rv;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_bvalid, s_axi_rvalid, pin_chk;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [17:0] ex;
    logic [33:0] rd_q[$];
    logic [1:0] wr_q[$];
    logic [17:0] pin_q[$];
    int n_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    int na = 0;
    int nb = 0;

    always #20 clk = ~clk;

    rbt_transceiver dut (.*, .s_axi_awprot(3'h0), .s_axi_wstrb(4'hf), .s_axi_arprot(3'h0));

    rbt_bus_partner u_partner (.*);

    ////////////////////////////////////////////////////////////////////////
    task check(input logic [33:0] seen, input logic [33:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task report_and_stop;
        $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // Write: address and data offered together, bready held until answered
    task axi_write(input logic [4:0] ad, input logic [31:0] d, input logic [1:0] er);
        wr_q.push_back(er);
        @(posedge clk);
        s_axi_awaddr <= ad;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'b0;
    endtask : axi_write

    task axi_read(input logic [4:0] ad, input logic [31:0] d, input logic [1:0] er);
        rd_q.push_back({er, d});
        @(posedge clk);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 1'b0;
    endtask : axi_read

    // Pins held well past the three-edge sync latency before any look
    task set_pins(input logic [3:0] c, input logic [7:0] av, input logic [7:0] bv);
        @(posedge clk);
        {output_enable_n, direction_select, a_bus_source_select, b_bus_source_select} <= c;
        a_val <= av;
        b_val <= bv;
        repeat (6) @(posedge clk);
    endtask : set_pins

    task expect_pins(input logic [17:0] e);
        pin_q.push_back(e);
        pin_chk <= 1'b1;
        @(posedge clk);
        pin_chk <= 1'b0;
    endtask : expect_pins

    // Capture pulses kept three cycles high and low so the sync never misses
    task capture(input logic ca, input logic cb, input logic [7:0] av, input logic [7:0] bv);
        @(posedge clk);
        a_to_b_capture_clock <= ca;
        b_to_a_capture_clock <= cb;
        repeat (3) @(posedge clk);
        a_to_b_capture_clock <= 1'b0;
        b_to_a_capture_clock <= 1'b0;
        repeat (3) @(posedge clk);
        if (ca) a_reg = av;
        if (cb) b_reg = bv;
        na += ca;
        nb += cb;
    endtask : capture

    ////////////////////////////////////////////////////////////////////////
    // Watcher: oldest note compared against what the outputs show
    always @(negedge clk) begin
        if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, rd_q.pop_front());
        if (s_axi_bvalid && s_axi_bready) check({32'h0, s_axi_bresp}, {32'h0, wr_q.pop_front()});
        if (pin_chk) check({16'h0, a_bus_oe_n, b_bus_oe_n, a_bus_oe_n ? 8'h00 : a_bus_out,
            b_bus_oe_n ? 8'h00 : b_bus_out}, {16'h0, pin_q.pop_front()});
    end

    // Hang guard, far above the run's length
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors = n_errors + 1;
            report_and_stop;
        end
    end

    initial begin
        pin_chk = 1'b0;
        a_reg = 8'h00;
        b_reg = 8'h00;
        rv = $urandom(32'h7160);
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        axi_read(RBT_CTRL_OFS, 32'h0, RBT_RESP_OKAY);
        axi_read(RBT_STATUS_OFS, 32'h1, RBT_RESP_OKAY);
        axi_read(RBT_COUNT_OFS, 32'h0, RBT_RESP_OKAY);
        axi_read(5'h14, 32'h0, RBT_RESP_SLVERR);
        axi_write(RBT_A_STORE_OFS, 32'hff, RBT_RESP_SLVERR);
        axi_read(RBT_A_STORE_OFS, 32'h0, RBT_RESP_OKAY);
        $display("Test register_map done");
        rv = $urandom();
        set_pins(4'b1000, rv[7:0], rv[15:8]);
        capture(1'b1, 1'b1, a_val, b_val);
        expect_pins({2'b11, 16'h0});
        set_pins(4'b1000, ~a_val, ~b_val);
        axi_read(RBT_A_STORE_OFS, {24'h0, a_reg}, RBT_RESP_OKAY);
        axi_read(RBT_B_STORE_OFS, {24'h0, b_reg}, RBT_RESP_OKAY);
        axi_read(RBT_COUNT_OFS, {16'(nb), 16'(na)}, RBT_RESP_OKAY);
        $display("Test isolation done");
        for (int i = 0; i < 8; i++) begin
            rv = $urandom();
            set_pins(4'b1000, rv[7:0], rv[15:8]);
            capture(1'b1, 1'b1, a_val, b_val);
            set_pins({1'b0, i[1], i[1] ? rv[16] : i[0], i[1] ? i[0] : rv[16]}, rv[31:24],
                rv[23:16]);
            case (i[1:0])
                2'd0: ex = {2'b01, b_val, 8'h00};
                2'd1: ex = {2'b01, ~b_reg, 8'h00};
                2'd2: ex = {2'b10, 8'h00, ~a_val};
                default: ex = {2'b10, 8'h00, ~a_reg};
            endcase
            expect_pins(ex);
            axi_read(RBT_STATUS_OFS, {26'h0, i[1], !i[1], b_bus_source_select,
                a_bus_source_select, i[1], 1'b0}, RBT_RESP_OKAY);
        end
        $display("Test modes done");
        rv = $urandom();
        set_pins(4'b0100, rv[7:0], rv[15:8]);
        capture(1'b1, 1'b1, a_val, ~a_val);
        set_pins(4'b0010, a_val, b_val);
        expect_pins({2'b01, ~b_reg, 8'h00});
        set_pins(4'b0101, a_val, b_val);
        expect_pins({2'b10, 8'h00, ~a_reg});
        $display("Test capture_while_driving done");
        set_pins(4'b1000, a_val, b_val);
        axi_write(RBT_CTRL_OFS, 32'h1, RBT_RESP_OKAY);
        axi_read(RBT_CTRL_OFS, 32'h1, RBT_RESP_OKAY);
        axi_read(RBT_COUNT_OFS, {16'(nb), 16'(na)}, RBT_RESP_OKAY);
        axi_write(RBT_CTRL_OFS, 32'h2, RBT_RESP_OKAY);
        axi_read(RBT_CTRL_OFS, 32'h0, RBT_RESP_OKAY);
        axi_read(RBT_COUNT_OFS, 32'h0, RBT_RESP_OKAY);
        $display("Test control done");
        repeat (4) @(posedge clk);
        report_and_stop;
    end
endmodule : tb_top
